// ==== sfp_pins.sv ====
// Pin-side logic of a serial flash: select, lanes, protection, pause and pin reset
// What this block does; R4, R17 and R18 are rules for the host
// R1 - Deselected: every output pin released to high impedance.
// R2 - Serial data ignored while select is high.
// R3 - Select low wakes the device and enables transfers.
// R4 - Host gives a select falling edge after power-up before instructions.
// R5 - Deselected device sits in low-power standby until selected.
// R6 - Single lane: input sampled on rising serial clock edge.
// R7 - Single lane: output lane one changes on falling serial clock edge.
// R8 - Dual and quad: lanes bidirectional, sample rising, drive falling.
// R9 - Quad uses protect pin as lane two, pause pin as lane three.
// R10 - Disable bit set and protect low block protection bit writes.
// R11 - Disable bit clear allows protection writes whatever the protect pin.
// R12 - Quad enable set drops write protect; pin is lane two only.
// R13 - Quad enable picks lane three, else select bit picks pause or reset.
// R14 - Pause while selected freezes the sequence and releases outputs.
// R15 - Pause released resumes the frozen sequence where it stopped.
// R16 - Reset pin low holds reset with outputs released.
// R17 - Host avoids pin reset during an internal write or erase.
// R18 - Host uses clock mode zero or three; idle level differs.
// R19 - While paused, clock edges and lane values are ignored.
`timescale 1ns/10ps
`default_nettype none

module sfp_pins (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_b_i,
  input  wire logic       sck_i,
  input  wire logic       sel_b_i,
  input  wire logic       data_lane_zero_i,
  output logic            data_lane_zero_o,
  output logic            data_lane_zero_oe_b_o,
  input  wire logic       data_lane_one_i,
  output logic            data_lane_one_o,
  output logic            data_lane_one_oe_b_o,
  input  wire logic       data_lane_two_i,
  output logic            data_lane_two_o,
  output logic            data_lane_two_oe_b_o,
  input  wire logic       data_lane_three_i,
  output logic            data_lane_three_o,
  output logic            data_lane_three_oe_b_o,
  input  wire logic [1:0] lane_width_i,
  input  wire logic       drive_en_i,
  input  wire logic [7:0] tx_byte_i,
  output logic            tx_take_o,
  output logic [7:0]      rx_byte_o,
  output logic            rx_valid_o,
  input  wire logic       pin_function_select_i,
  input  wire logic       sr_wr_i,
  input  wire logic [5:0] sr_wr_data_i,
  output logic            sr_wr_blocked_o,
  output logic [5:0]      status_bits_o,
  output logic            selected_o,
  output logic            standby_o,
  output logic            paused_o,
  output logic            pin_reset_o
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Every pin crosses two flops; sync1 feeds only sync2.
  logic [5:0] sync1_q;
  logic [5:0] sync2_q;
  logic [5:0] pins_raw;
  assign pins_raw = {sel_b_i, sck_i, data_lane_three_i, data_lane_two_i,
                     data_lane_one_i, data_lane_zero_i};

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync1_q <= sfp_pkg::SYNC_RESET;
      sync2_q <= sfp_pkg::SYNC_RESET;
    end else begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
    end
  end

  // ----------------------------------------------------------------
  // Pin roles and operating conditions
  // ----------------------------------------------------------------
  logic [5:0] sr_q;
  logic       armed_q;
  logic       sck_prev_q;
  logic       quad_on;
  logic       sel_low;
  logic       lane3_low;
  logic       pause_act;
  logic       reset_act;
  logic       comm_ok;
  logic       drive_ok;
  logic       sck_rise;
  logic       sck_fall;
  logic [1:0] width_eff;
  logic [3:0] step;
  assign quad_on   = sr_q[sfp_pkg::SR_QE_POS];
  assign sel_low   = ~sync2_q[sfp_pkg::PIN_SEL];
  assign lane3_low = ~sync2_q[sfp_pkg::PIN_L3];
  assign pause_act = ~quad_on & ~pin_function_select_i & lane3_low & sel_low; // R13 R14
  assign reset_act = ~quad_on & pin_function_select_i & lane3_low; // R13 R16
  // Transfers only after a seen high-to-low select since reset.
  assign comm_ok   = sel_low & armed_q & ~pause_act & ~reset_act; // R2 R3 R4 R19
  assign drive_ok  = comm_ok & drive_en_i;
  assign sck_rise  = sync2_q[sfp_pkg::PIN_SCK] & ~sck_prev_q;
  assign sck_fall  = ~sync2_q[sfp_pkg::PIN_SCK] & sck_prev_q;
  // Quad width only counts while lanes two and three are data lanes.
  assign width_eff = (lane_width_i == sfp_pkg::LANES_FOUR && !quad_on) ?
                     sfp_pkg::LANES_ONE : lane_width_i; // R9 R12

  always_comb begin
    case (width_eff)
      sfp_pkg::LANES_TWO:  step = sfp_pkg::STEP_TWO;
      sfp_pkg::LANES_FOUR: step = sfp_pkg::STEP_FOUR;
      default:             step = sfp_pkg::STEP_ONE;
    endcase
  end

  // ----------------------------------------------------------------
  // Select tracking and clock edge history
  // ----------------------------------------------------------------
  logic armed_d;
  logic sck_prev_d;
  always_comb begin
    armed_d    = armed_q;
    sck_prev_d = sync2_q[sfp_pkg::PIN_SCK];
    if (!sel_low) begin
      armed_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      armed_q    <= 1'b0;
      // Same level as the preset sync flop, so reset shows no false clock edge
      sck_prev_q <= sfp_pkg::SYNC_RESET[sfp_pkg::PIN_SCK];
    end else begin
      armed_q    <= armed_d;
      sck_prev_q <= sck_prev_d;
    end
  end

  // ----------------------------------------------------------------
  // Receive shifter
  // ----------------------------------------------------------------
  logic [7:0] rx_sh_q;
  logic [7:0] rx_sh_d;
  logic [3:0] rx_cnt_q;
  logic [3:0] rx_cnt_d;
  logic [7:0] rx_byte_q;
  logic [7:0] rx_byte_d;
  logic       rx_valid_q;
  logic       rx_valid_d;
  logic [7:0] rx_next;
  logic [3:0] rx_sum;
  always_comb begin
    rx_sh_d    = rx_sh_q;
    rx_cnt_d   = rx_cnt_q;
    rx_byte_d  = rx_byte_q;
    rx_valid_d = 1'b0;
    rx_sum     = rx_cnt_q + step;
    case (width_eff)
      sfp_pkg::LANES_TWO:  rx_next = {rx_sh_q[5:0], sync2_q[sfp_pkg::PIN_L1],
                                      sync2_q[sfp_pkg::PIN_L0]}; // R8
      sfp_pkg::LANES_FOUR: rx_next = {rx_sh_q[3:0], sync2_q[3:0]}; // R9
      default:             rx_next = {rx_sh_q[6:0], sync2_q[sfp_pkg::PIN_L0]}; // R6
    endcase
    if (!sel_low || reset_act) begin
      rx_cnt_d = sfp_pkg::CNT_RESET; // R2 R16
    end else if (comm_ok && sck_rise) begin
      // Paused cycles never reach here, so the count is kept intact.
      rx_sh_d = rx_next; // R6 R15
      if (rx_sum == sfp_pkg::BYTE_BITS) begin
        rx_cnt_d   = sfp_pkg::CNT_RESET;
        rx_byte_d  = rx_next;
        rx_valid_d = 1'b1;
      end else begin
        rx_cnt_d = rx_sum;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_sh_q    <= sfp_pkg::BYTE_RESET;
      rx_cnt_q   <= sfp_pkg::CNT_RESET;
      rx_byte_q  <= sfp_pkg::BYTE_RESET;
      rx_valid_q <= 1'b0;
    end else begin
      rx_sh_q    <= rx_sh_d;
      rx_cnt_q   <= rx_cnt_d;
      rx_byte_q  <= rx_byte_d;
      rx_valid_q <= rx_valid_d;
    end
  end

  // ----------------------------------------------------------------
  // Transmit shifter
  // ----------------------------------------------------------------
  logic [7:0] tx_sh_q;
  logic [7:0] tx_sh_d;
  logic [3:0] tx_cnt_q;
  logic [3:0] tx_cnt_d;
  logic [3:0] out_q;
  logic [3:0] out_d;
  logic       tx_take_q;
  logic       tx_take_d;
  logic [7:0] tx_src;
  logic [3:0] tx_sum;
  always_comb begin
    tx_sh_d   = tx_sh_q;
    tx_cnt_d  = tx_cnt_q;
    out_d     = out_q;
    tx_take_d = 1'b0;
    tx_sum    = tx_cnt_q + step;
    tx_src    = (tx_cnt_q == sfp_pkg::CNT_RESET) ? tx_byte_i : tx_sh_q;
    if (!sel_low || reset_act) begin
      tx_cnt_d = sfp_pkg::CNT_RESET;
    end else if (drive_ok && sck_fall) begin
      case (width_eff)
        sfp_pkg::LANES_TWO:  out_d[1:0] = tx_src[7:6]; // R8
        sfp_pkg::LANES_FOUR: out_d      = tx_src[7:4]; // R8 R9
        default:             out_d[1]   = tx_src[7]; // R7
      endcase
      tx_sh_d   = tx_src << step;
      tx_take_d = (tx_cnt_q == sfp_pkg::CNT_RESET);
      tx_cnt_d  = (tx_sum == sfp_pkg::BYTE_BITS) ? sfp_pkg::CNT_RESET : tx_sum;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_sh_q   <= sfp_pkg::BYTE_RESET;
      tx_cnt_q  <= sfp_pkg::CNT_RESET;
      out_q     <= 4'h0;
      tx_take_q <= 1'b0;
    end else begin
      tx_sh_q   <= tx_sh_d;
      tx_cnt_q  <= tx_cnt_d;
      out_q     <= out_d;
      tx_take_q <= tx_take_d;
    end
  end

  // ----------------------------------------------------------------
  // Protection bits
  // ----------------------------------------------------------------
  logic [5:0] sr_d;
  logic       blocked_q;
  logic       blocked_d;
  logic       wr_locked;
  // Write protect only applies while lane two is not a data lane.
  assign wr_locked = sr_q[sfp_pkg::SR_SWD_POS] & ~quad_on &
                     ~sync2_q[sfp_pkg::PIN_L2]; // R10 R11 R12
  always_comb begin
    sr_d      = sr_q;
    blocked_d = 1'b0;
    if (sr_wr_i) begin
      if (wr_locked) begin
        blocked_d = 1'b1; // R10
      end else begin
        sr_d = sr_wr_data_i; // R11
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sr_q      <= sfp_pkg::SR_RESET;
      blocked_q <= 1'b0;
    end else begin
      sr_q      <= sr_d;
      blocked_q <= blocked_d;
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers and status
  // ----------------------------------------------------------------
  assign data_lane_zero_o       = out_q[0];
  assign data_lane_one_o        = out_q[1];
  assign data_lane_two_o        = out_q[2];
  assign data_lane_three_o      = out_q[3];
  // Enables are low only while driving; deselect, pause, reset release all.
  assign data_lane_one_oe_b_o   = ~drive_ok; // R1 R7 R14 R16
  assign data_lane_zero_oe_b_o  = ~(drive_ok && width_eff != sfp_pkg::LANES_ONE); // R1 R8
  assign data_lane_two_oe_b_o   = ~(drive_ok && width_eff == sfp_pkg::LANES_FOUR); // R1 R9
  assign data_lane_three_oe_b_o = ~(drive_ok && width_eff == sfp_pkg::LANES_FOUR); // R1 R9
  assign tx_take_o       = tx_take_q;
  assign rx_byte_o       = rx_byte_q;
  assign rx_valid_o      = rx_valid_q;
  assign sr_wr_blocked_o = blocked_q;
  assign status_bits_o   = sr_q;
  assign selected_o      = sel_low; // R3
  assign standby_o       = ~sel_low; // R5
  assign paused_o        = pause_act; // R14
  assign pin_reset_o     = reset_act; // R16
endmodule

`default_nettype wire

// ==== sfp_pkg.sv ====
// Shared constants for the serial flash pin interface block
package sfp_pkg;

  // ----------------------------------------------------------------
  // Lane width codes
  // ----------------------------------------------------------------
  localparam logic [1:0] LANES_ONE  = 2'h0;
  localparam logic [1:0] LANES_TWO  = 2'h1;
  localparam logic [1:0] LANES_FOUR = 2'h2;

  // ----------------------------------------------------------------
  // Bits moved per serial clock edge for each width
  // ----------------------------------------------------------------
  localparam logic [3:0] STEP_ONE  = 4'h1;
  localparam logic [3:0] STEP_TWO  = 4'h2;
  localparam logic [3:0] STEP_FOUR = 4'h4;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // ----------------------------------------------------------------
  // Protection bit positions and reset values
  // ----------------------------------------------------------------
  localparam int         SR_W         = 6;
  localparam int         SR_SWD_POS   = 5;
  localparam int         SR_QE_POS    = 4;
  localparam logic [5:0] SR_RESET     = 6'h00;
  localparam logic [3:0] CNT_RESET    = 4'h0;
  localparam logic [7:0] BYTE_RESET   = 8'h00;
  localparam logic [5:0] SYNC_RESET   = 6'h3F;

  // ----------------------------------------------------------------
  // Positions inside the synchronised pin vector
  // ----------------------------------------------------------------
  localparam int PIN_L0  = 0;
  localparam int PIN_L1  = 1;
  localparam int PIN_L2  = 2;
  localparam int PIN_L3  = 3;
  localparam int PIN_SCK = 4;
  localparam int PIN_SEL = 5;

endpackage

// ==== sfp_pins_checker.sv ====
// Assertion checker for the serial flash pin block
`timescale 1ns/10ps
`default_nettype none
module sfp_pins_checker (
  input wire logic       clk_sys_i,
  input wire logic       rst_b_i,
  input wire logic       sr_wr_i,
  input wire logic [5:0] sr_wr_data_i,
  input wire logic       sr_wr_blocked_o,
  input wire logic [5:0] status_bits_o,
  input wire logic       standby_o,
  input wire logic       selected_o,
  input wire logic       paused_o,
  input wire logic       pin_reset_o,
  input wire logic       rx_valid_o,
  input wire logic       data_lane_zero_oe_b_o,
  input wire logic       data_lane_one_oe_b_o,
  input wire logic       data_lane_two_oe_b_o,
  input wire logic       data_lane_three_oe_b_o
);
  // --------
  // Checks
  // --------
  logic oe_all;
  assign oe_all = data_lane_zero_oe_b_o & data_lane_one_oe_b_o
                & data_lane_two_oe_b_o & data_lane_three_oe_b_o;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  a_desel_released: assert property (standby_o |-> oe_all)
    else $error("lane driven while idle");
  a_standby_flag: assert property (standby_o != selected_o)
    else $error("standby and select agree");
  a_pause_released: assert property (paused_o |-> data_lane_one_oe_b_o)
    else $error("lane one driven in pause");
  a_reset_released: assert property (pin_reset_o |-> oe_all)
    else $error("lane driven in pin reset");
  a_quad_no_pause: assert property (status_bits_o[4] |-> !paused_o && !pin_reset_o)
    else $error("shared pin not a lane");
  a_free_write: assert property (sr_wr_i && !status_bits_o[5] |=>
    status_bits_o == $past(sr_wr_data_i) && !sr_wr_blocked_o)
    else $error("open write not applied");
  a_block_cause: assert property (sr_wr_blocked_o |-> $past(sr_wr_i) &&
    $past(status_bits_o[5]) && !$past(status_bits_o[4]) && $stable(status_bits_o))
    else $error("bad refusal");
  a_pause_idle: assert property (paused_o |=> !rx_valid_o)
    else $error("byte done in pause");
  c_rx: cover property (rx_valid_o);
  c_blocked: cover property (sr_wr_blocked_o);
  c_pause: cover property (paused_o);
endmodule
bind sfp_pins sfp_pins_checker u_chk (.clk_sys_i, .rst_b_i, .sr_wr_i, .sr_wr_data_i,
  .sr_wr_blocked_o, .status_bits_o, .standby_o, .selected_o, .paused_o, .pin_reset_o,
  .rx_valid_o, .data_lane_zero_oe_b_o, .data_lane_one_oe_b_o, .data_lane_two_oe_b_o,
  .data_lane_three_oe_b_o);
`default_nettype wire

// ==== sfp_host_model.sv ====
// Host controller model driving select, serial clock and lanes
`timescale 1ns/10ps
`default_nettype none
module sfp_host_model (
  input  wire logic  lane_one_i,
  output logic       sck_o,
  output logic       sel_b_o,
  output logic [3:0] lane_o,
  output logic       rx_bit_o
);
  // --------
  // Mode three: clock rests high outside frames
  // --------
  initial begin
    sck_o = 1'b1;
    sel_b_o = 1'b1;
    lane_o = 4'hF;
    rx_bit_o = 1'b0;
  end
  task automatic select(input logic b);
    sel_b_o = b;
    #400;
  endtask
  task automatic set_lanes(input logic [3:0] v);
    lane_o = v;
  endtask
  // Sample late in the high phase, the device answer lags by a few clocks
  task automatic step(input logic [3:0] v);
    lane_o = v;
    sck_o = 1'b0;
    #100;
    sck_o = 1'b1;
    #99;
    rx_bit_o = lane_one_i;
    #1;
  endtask
endmodule
`default_nettype wire

// ==== sfp_pins_tb.sv ====
// Self-checking testbench for the serial flash pin block
`timescale 1ns/10ps
`default_nettype none
module sfp_pins_tb;
  logic clk_sys_i, rst_b_i, drive_en, pfs, sr_wr;
  logic sck, sel_b, rx_bit, blk, rxv, stb, sel, paused, prst, bk, tk;
  logic [1:0] width;
  logic [3:0] hlane, lo, oe_b, lw;
  logic [5:0] sr_d, sr;
  logic [7:0] tx_byte, rx_byte, got_rx, sh;
  int bad_count = 0, tests_run = 0, n_rx = 0, n_tk = 0;
  assign lw = (oe_b & hlane) | (~oe_b & lo);
  sfp_host_model hm (.lane_one_i(lw[1]), .sck_o(sck), .sel_b_o(sel_b), .lane_o(hlane),
    .rx_bit_o(rx_bit));
  sfp_pins uut (.clk_sys_i, .rst_b_i, .sck_i(sck), .sel_b_i(sel_b),
    .data_lane_zero_i(lw[0]), .data_lane_zero_o(lo[0]), .data_lane_zero_oe_b_o(oe_b[0]),
    .data_lane_one_i(lw[1]), .data_lane_one_o(lo[1]), .data_lane_one_oe_b_o(oe_b[1]),
    .data_lane_two_i(lw[2]), .data_lane_two_o(lo[2]), .data_lane_two_oe_b_o(oe_b[2]),
    .data_lane_three_i(lw[3]), .data_lane_three_o(lo[3]), .data_lane_three_oe_b_o(oe_b[3]),
    .lane_width_i(width), .drive_en_i(drive_en), .tx_byte_i(tx_byte), .tx_take_o(tk),
    .rx_byte_o(rx_byte), .rx_valid_o(rxv), .pin_function_select_i(pfs), .sr_wr_i(sr_wr),
    .sr_wr_data_i(sr_d), .sr_wr_blocked_o(blk), .status_bits_o(sr), .selected_o(sel),
    .standby_o(stb), .paused_o(paused), .pin_reset_o(prst));
  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  // Pulses stand a whole cycle, so the settled falling edge sees each once
  always @(negedge clk_sys_i) begin
    if (rxv === 1'b1) begin
      got_rx <= rx_byte;
      n_rx <= n_rx + 1;
    end
    if (tk === 1'b1) begin
      n_tk <= n_tk + 1;
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] d);
    repeat (3) @(negedge clk_sys_i);
    sr_wr = 1'b1;
    sr_d = d;
    @(negedge clk_sys_i);
    sr_wr = 1'b0;
    bk = blk;
  endtask
  // Pause mid-byte must keep the bits already shifted in
  task automatic xfer(input logic [7:0] b, input int nb, input bit pz, input logic sb);
    logic [3:0] v;
    hm.select(sb);
    chk(sel, !sb);
    for (int i = 0; i < 8 / nb; i++) begin
      v = (nb == 4) ? b[7:4] : (nb == 2) ? {2'h3, b[7:6]} : {3'h7, b[7]};
      if (pz && i == 4) begin
        repeat (3) hm.step(4'h6);
        chk(paused, 1'b1);
        chk(oe_b[1], 1'b1);
      end
      hm.step(v);
      b = b << nb;
    end
    hm.select(1'b1);
    @(negedge clk_sys_i);
  endtask
  task automatic end_of_test;
    if (bad_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    end_of_test;
  end
  initial begin
    rst_b_i = 1'b0;
    drive_en = 1'b0;
    pfs = 1'b0;
    sr_wr = 1'b0;
    width = 2'h0;
    sr_d = 6'h00;
    tx_byte = 8'h00;
    repeat (20) @(negedge clk_sys_i);
    rst_b_i = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    chk(stb, 1'b1);
    chk(oe_b, 4'hF);
    wr(6'h2F);
    chk(sr, 6'h2F);
    hm.set_lanes(4'hB);
    wr(6'h00);
    chk(bk, 1'b1);
    chk(sr, 6'h2F);
    hm.set_lanes(4'hF);
    wr(6'h00);
    chk(sr, 6'h00);
    xfer(8'hA5, 1, 1, 1'b0);
    chk(got_rx, 8'hA5);
    chk(n_rx[7:0], 8'h01);
    width = 2'h1;
    xfer(8'h3C, 2, 0, 1'b0);
    chk(got_rx, 8'h3C);
    wr(6'h30);
    hm.set_lanes(4'hB);
    wr(6'h10);
    chk(sr, 6'h10);
    width = 2'h2;
    xfer(8'h96, 4, 0, 1'b0);
    chk(got_rx, 8'h96);
    drive_en = 1'b1;
    tx_byte = 8'h5A;
    hm.select(1'b0);
    hm.step(4'hF);
    sh[7:4] = lo;
    hm.step(4'hF);
    sh[3:0] = lo;
    hm.select(1'b1);
    drive_en = 1'b0;
    chk(sh, 8'h5A);
    wr(6'h0F);
    width = 2'h0;
    drive_en = 1'b1;
    tx_byte = 8'hC3;
    hm.select(1'b0);
    repeat (8) begin
      hm.step(4'hF);
      sh = {sh[6:0], rx_bit};
    end
    hm.select(1'b1);
    @(negedge clk_sys_i);
    drive_en = 1'b0;
    chk(sh, 8'hC3);
    chk(n_tk[7:0], 8'h02);
    sh = n_rx[7:0];
    xfer(8'h00, 1, 0, 1'b1);
    chk(n_rx[7:0], sh);
    drive_en = 1'b1;
    hm.set_lanes(4'h7);
    hm.select(1'b0);
    chk(paused, 1'b1);
    chk(oe_b, 4'hF);
    pfs = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    chk(prst, 1'b1);
    chk(oe_b, 4'hF);
    chk(sr, 6'h0F);
    hm.select(1'b1);
    drive_en = 1'b0;
    end_of_test;
  end
endmodule
`default_nettype wire
